// [core/dpdc_coeff_scale.sv]
`timescale 1ns/100ps
`default_nettype none
module dpdc_coeff_scale
(
  // coefficient fields
  input  wire logic [11:0] linear,
  input  wire logic [4:0]  mult_exp,
  input  wire logic [2:0]  div_exp,
  // scaled result
  output logic      [43:0] scaled
);
  logic [43:0] widened;

  // multiply first so the divider shift loses fewer bits
  always_comb
  begin
    widened = {32'h0000_0000, linear} << mult_exp;
    scaled  = widened >> div_exp;
  end
endmodule : dpdc_coeff_scale
`default_nettype wire

// [core/dpdc_fb_divider.sv]
`timescale 1ns/100ps
`default_nettype none
module dpdc_fb_divider
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // feedback sample and settings
  input  wire logic        feedback_clock_input,
  input  wire logic        invert,
  input  wire logic        prescale,
  input  wire logic [15:0] div_value,
  // divided output
  output logic             fb_div_out
);
  logic        sample_prev;
  logic        edge_in;
  logic        presc_tog;
  logic        count_en;
  logic [15:0] count;

  // falling edges count when inverted
  always_comb
  begin
    edge_in  = invert ? (sample_prev & ~feedback_clock_input)
                      : (~sample_prev & feedback_clock_input);
    count_en = edge_in & (~prescale | presc_tog);
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      sample_prev <= 1'b0;
    else
      sample_prev <= feedback_clock_input;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      presc_tog <= 1'b0;
    else if (edge_in)
      presc_tog <= ~presc_tog;
  end

  // ratio is value plus one: terminal count at div_value
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      count      <= 16'h0000;
      fb_div_out <= 1'b0;
    end
    else
    begin
      fb_div_out <= 1'b0;
      if (count_en)
      begin
        if (count >= div_value)
        begin
          count      <= 16'h0000;
          fb_div_out <= 1'b1;
        end
        else
          count <= count + 16'h0001;
      end
    end
  end
endmodule : dpdc_fb_divider
`default_nettype wire

// [core/dpdc_pkg.sv]
`default_nettype none
package dpdc_pkg;
  // register byte addresses
  localparam logic [15:0] ADDR_FB_DIV_LO    = 16'h0104;
  localparam logic [15:0] ADDR_FB_DIV_HI    = 16'h0105;
  localparam logic [15:0] ADDR_FB_CTRL      = 16'h0106;
  localparam logic [15:0] ADDR_LOOP_RATE    = 16'h0107;
  localparam logic [15:0] ADDR_PROP_LO      = 16'h0108;
  localparam logic [15:0] ADDR_PROP_HI      = 16'h0109;
  localparam logic [15:0] ADDR_PROP_MULT    = 16'h010a;
  localparam logic [15:0] ADDR_PROP_DIV     = 16'h010b;
  localparam logic [15:0] ADDR_INTEG_LO     = 16'h010c;
  localparam logic [15:0] ADDR_INTEG_HI     = 16'h010d;
  localparam logic [15:0] ADDR_INTEG_DIV    = 16'h010e;
  localparam logic [15:0] ADDR_THIRD_LO     = 16'h010f;
  localparam logic [15:0] ADDR_THIRD_HI     = 16'h0110;
  localparam logic [15:0] ADDR_THIRD_DIV    = 16'h0111;
  localparam logic [15:0] ADDR_EST_B0       = 16'h0115;
  localparam logic [15:0] ADDR_EST_B1       = 16'h0116;
  localparam logic [15:0] ADDR_EST_B2       = 16'h0117;
  // field positions and widths
  localparam int          FB_INVERT_BIT     = 7;
  localparam int          FB_PRESCALE_BIT   = 0;
  localparam int          RATE_EXP_W        = 5;
  localparam int          MULT_EXP_W        = 5;
  localparam int          DIV_EXP_W         = 3;
  localparam int          LIN_HI_W          = 4;
  localparam int          COEFF_W           = 12;
  localparam int          SCALED_W          = 44;
  localparam int          FB_DIV_W          = 16;
  localparam int          EST_W             = 24;
  // reset values
  localparam logic [7:0]  RST_BYTE          = 8'h00;
  localparam logic [7:0]  RST_LOOP_RATE     = 8'h05;
endpackage : dpdc_pkg
`default_nettype wire

// [core/dpdc_regs.sv]
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - invert bit makes divider count falling edges
// - prescale bit adds divide-by-two ahead
// - loop filter rate is clock over 2^field
// - converter rate equals system clock rate
// - proportional linear value split low/high bytes
// - proportional scaled by multiplier and divider
// - integral coefficient linear with divider field
// - third coefficient linear with divider field
// - estimate word read back as three bytes
// - feedback ratio equals programmed value plus one
module dpdc_regs
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // register port
  input  wire logic [15:0] reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  // feedback path
  input  wire logic        feedback_clock_input,
  output logic             fb_div_out,
  // frequency estimator
  input  wire logic [23:0] freq_estimate_word,
  // loop filter controls
  output logic             loop_filter_tick,
  output logic      [43:0] prop_coeff,
  output logic      [43:0] integ_coeff,
  output logic      [43:0] third_coeff
);
  // register fields
  logic [7:0]  fb_div_lo;
  logic [7:0]  fb_div_hi;
  logic        fb_invert;
  logic        fb_prescale;
  logic [4:0]  loop_rate_exp;
  logic [7:0]  prop_lo;
  logic [3:0]  prop_hi;
  logic [4:0]  prop_mult;
  logic [2:0]  prop_div;
  logic [7:0]  integ_lo;
  logic [3:0]  integ_hi;
  logic [2:0]  integ_div;
  logic [7:0]  third_lo;
  logic [3:0]  third_hi;
  logic [2:0]  third_div;
  logic [30:0] rate_count;
  logic [30:0] rate_term;
  logic [7:0]  next_rdata;
  logic        wr_fb_lo;
  logic        wr_fb_hi;
  logic        wr_fb_ctrl;
  logic        wr_loop_rate;
  logic        wr_prop_lo;
  logic        wr_prop_hi;
  logic        wr_prop_mult;
  logic        wr_prop_div;
  logic        wr_integ_lo;
  logic        wr_integ_hi;
  logic        wr_integ_div;
  logic        wr_third_lo;
  logic        wr_third_hi;
  logic        wr_third_div;

  function automatic logic hit(input logic [15:0] a, input logic [15:0] target);
    hit = (a == target);
  endfunction : hit

  // decoded write strobes; estimate bytes get none, so writes there drop
  // one strobe per register keeps each field block small
  always_comb
  begin
    wr_fb_lo     = reg_wr && hit(reg_addr, dpdc_pkg::ADDR_FB_DIV_LO);
    wr_fb_hi     = reg_wr && hit(reg_addr, dpdc_pkg::ADDR_FB_DIV_HI);
    wr_fb_ctrl   = reg_wr && hit(reg_addr, dpdc_pkg::ADDR_FB_CTRL);
    wr_loop_rate = reg_wr && hit(reg_addr, dpdc_pkg::ADDR_LOOP_RATE);
    wr_prop_lo   = reg_wr && hit(reg_addr, dpdc_pkg::ADDR_PROP_LO);
    wr_prop_hi   = reg_wr && hit(reg_addr, dpdc_pkg::ADDR_PROP_HI);
    wr_prop_mult = reg_wr && hit(reg_addr, dpdc_pkg::ADDR_PROP_MULT);
    wr_prop_div  = reg_wr && hit(reg_addr, dpdc_pkg::ADDR_PROP_DIV);
    wr_integ_lo  = reg_wr && hit(reg_addr, dpdc_pkg::ADDR_INTEG_LO);
    wr_integ_hi  = reg_wr && hit(reg_addr, dpdc_pkg::ADDR_INTEG_HI);
    wr_integ_div = reg_wr && hit(reg_addr, dpdc_pkg::ADDR_INTEG_DIV);
    wr_third_lo  = reg_wr && hit(reg_addr, dpdc_pkg::ADDR_THIRD_LO);
    wr_third_hi  = reg_wr && hit(reg_addr, dpdc_pkg::ADDR_THIRD_HI);
    wr_third_div = reg_wr && hit(reg_addr, dpdc_pkg::ADDR_THIRD_DIV);
  end

  // feedback divider value, low byte first
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      fb_div_lo <= dpdc_pkg::RST_BYTE;
      fb_div_hi <= dpdc_pkg::RST_BYTE;
    end
    else
    begin
      if (wr_fb_lo)
        fb_div_lo <= reg_wdata;
      if (wr_fb_hi)
        fb_div_hi <= reg_wdata;
    end
  end

  // feedback control: reserved bits are not stored, so they read zero
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      fb_invert   <= 1'b0;
      fb_prescale <= 1'b0;
    end
    else if (wr_fb_ctrl)
    begin
      fb_invert   <= reg_wdata[dpdc_pkg::FB_INVERT_BIT];
      fb_prescale <= reg_wdata[dpdc_pkg::FB_PRESCALE_BIT];
    end
  end

  // loop rate register
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      loop_rate_exp <= dpdc_pkg::RST_LOOP_RATE[4:0];
    else if (wr_loop_rate)
      loop_rate_exp <= reg_wdata[4:0];
  end

  // proportional coefficient fields
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      prop_lo   <= dpdc_pkg::RST_BYTE;
      prop_hi   <= 4'h0;
      prop_mult <= 5'h00;
      prop_div  <= 3'h0;
    end
    else
    begin
      if (wr_prop_lo)
        prop_lo <= reg_wdata;
      if (wr_prop_hi)
        prop_hi <= reg_wdata[3:0];
      if (wr_prop_mult)
        prop_mult <= reg_wdata[4:0];
      if (wr_prop_div)
        prop_div <= reg_wdata[2:0];
    end
  end

  // integral coefficient fields; no multiplier field here
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      integ_lo  <= dpdc_pkg::RST_BYTE;
      integ_hi  <= 4'h0;
      integ_div <= 3'h0;
    end
    else
    begin
      if (wr_integ_lo)
        integ_lo <= reg_wdata;
      if (wr_integ_hi)
        integ_hi <= reg_wdata[3:0];
      if (wr_integ_div)
        integ_div <= reg_wdata[2:0];
    end
  end

  // third coefficient fields
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      third_lo  <= dpdc_pkg::RST_BYTE;
      third_hi  <= 4'h0;
      third_div <= 3'h0;
    end
    else
    begin
      if (wr_third_lo)
        third_lo <= reg_wdata;
      if (wr_third_hi)
        third_hi <= reg_wdata[3:0];
      if (wr_third_div)
        third_div <= reg_wdata[2:0];
    end
  end

  // loop filter tick: system clock is the converter rate
  always_comb
  begin
    rate_term = (31'h0000_0001 << loop_rate_exp) - 31'h0000_0001;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      rate_count       <= 31'h0000_0000;
      loop_filter_tick <= 1'b0;
    end
    // a lower exponent mid-count wraps at once
    else if (rate_count >= rate_term)
    begin
      rate_count       <= 31'h0000_0000;
      loop_filter_tick <= 1'b1;
    end
    else
    begin
      rate_count       <= rate_count + 31'h0000_0001;
      loop_filter_tick <= 1'b0;
    end
  end

  // read mux; unmapped and reserved read zero
  // estimate bytes are read live, so a multi-byte read can tear
  always_comb
  begin
    next_rdata = 8'h00;
    unique case (reg_addr)
      dpdc_pkg::ADDR_FB_DIV_LO: next_rdata = fb_div_lo;
      dpdc_pkg::ADDR_FB_DIV_HI: next_rdata = fb_div_hi;
      dpdc_pkg::ADDR_FB_CTRL:   next_rdata = {fb_invert, 6'h00, fb_prescale};
      dpdc_pkg::ADDR_LOOP_RATE: next_rdata = {3'h0, loop_rate_exp};
      dpdc_pkg::ADDR_PROP_LO:   next_rdata = prop_lo;
      dpdc_pkg::ADDR_PROP_HI:   next_rdata = {4'h0, prop_hi};
      dpdc_pkg::ADDR_PROP_MULT: next_rdata = {3'h0, prop_mult};
      dpdc_pkg::ADDR_PROP_DIV:  next_rdata = {5'h00, prop_div};
      dpdc_pkg::ADDR_INTEG_LO:  next_rdata = integ_lo;
      dpdc_pkg::ADDR_INTEG_HI:  next_rdata = {4'h0, integ_hi};
      dpdc_pkg::ADDR_INTEG_DIV: next_rdata = {5'h00, integ_div};
      dpdc_pkg::ADDR_THIRD_LO:  next_rdata = third_lo;
      dpdc_pkg::ADDR_THIRD_HI:  next_rdata = {4'h0, third_hi};
      dpdc_pkg::ADDR_THIRD_DIV: next_rdata = {5'h00, third_div};
      dpdc_pkg::ADDR_EST_B0:    next_rdata = freq_estimate_word[7:0];
      dpdc_pkg::ADDR_EST_B1:    next_rdata = freq_estimate_word[15:8];
      dpdc_pkg::ADDR_EST_B2:    next_rdata = freq_estimate_word[23:16];
      default:                  next_rdata = 8'h00;
    endcase
  end

  // data only valid the cycle after a read; zero otherwise
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      reg_rdata <= next_rdata;
    else
      reg_rdata <= 8'h00;
  end

  // feedback divider: ratio is the 16-bit value plus one
  dpdc_fb_divider u_fb_divider
  (
    .core_clk             (core_clk),
    .rst                  (rst),
    .feedback_clock_input (feedback_clock_input),
    .invert               (fb_invert),
    .prescale             (fb_prescale),
    .div_value            ({fb_div_hi, fb_div_lo}),
    .fb_div_out           (fb_div_out)
  );

  dpdc_coeff_scale u_prop_scale
  (
    .linear   ({prop_hi, prop_lo}),
    .mult_exp (prop_mult),
    .div_exp  (prop_div),
    .scaled   (prop_coeff)
  );

  dpdc_coeff_scale u_integ_scale
  (
    .linear   ({integ_hi, integ_lo}),
    .mult_exp (5'h00),
    .div_exp  (integ_div),
    .scaled   (integ_coeff)
  );

  dpdc_coeff_scale u_third_scale
  (
    .linear   ({third_hi, third_lo}),
    .mult_exp (5'h00),
    .div_exp  (third_div),
    .scaled   (third_coeff)
  );
endmodule : dpdc_regs
`default_nettype wire

// [verification/dpdc_props.sv]
`timescale 1ns/100ps
`default_nettype none
module dpdc_props
(
  // clock and reset
  input wire logic        core_clk,
  input wire logic        rst,
  // register port
  input wire logic [15:0] reg_addr,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  // datapath
  input wire logic        fb_div_out,
  input wire logic [23:0] freq_estimate_word,
  input wire logic        loop_filter_tick,
  input wire logic [43:0] prop_coeff,
  input wire logic [43:0] integ_coeff,
  input wire logic [43:0] third_coeff
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  // estimate as it stood at the read edge
  logic [23:0] est_q;
  always_ff @(posedge core_clk)
  begin
    est_q <= freq_estimate_word;
  end

  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside read slot");
  est_low_a: assert property (reg_rd && reg_addr == dpdc_pkg::ADDR_EST_B0
    |=> reg_rdata == est_q[7:0]) else $error("estimate low byte wrong");
  est_high_a: assert property (reg_rd && reg_addr == dpdc_pkg::ADDR_EST_B2
    |=> reg_rdata == est_q[23:16]) else $error("estimate top byte wrong");
  resv_addr_a: assert property (reg_rd && !(reg_addr inside
    {[dpdc_pkg::ADDR_FB_DIV_LO:dpdc_pkg::ADDR_THIRD_DIV],
     [dpdc_pkg::ADDR_EST_B0:dpdc_pkg::ADDR_EST_B2]}) |=> reg_rdata == 8'h00)
    else $error("unmapped address not zero");
  ctrl_resv_a: assert property (reg_rd && reg_addr == dpdc_pkg::ADDR_FB_CTRL
    |=> reg_rdata[6:1] == 6'h00) else $error("reserved control bits not zero");
  fb_pulse_a: assert property (fb_div_out |=> !fb_div_out)
    else $error("divider pulse too long");
  prop_hold_a: assert property ($changed(prop_coeff) |-> $past(reg_wr))
    else $error("proportional moved without write");
  integ_hold_a: assert property ($changed(integ_coeff) |-> $past(reg_wr))
    else $error("integral moved without write");
  third_hold_a: assert property ($changed(third_coeff) |-> $past(reg_wr))
    else $error("third moved without write");

  cover property (loop_filter_tick ##1 loop_filter_tick);
  cover property (fb_div_out);
  cover property (reg_rd && reg_addr == dpdc_pkg::ADDR_EST_B2);
endmodule : dpdc_props

bind dpdc_regs dpdc_props u_props
(
  .core_clk           (core_clk),
  .rst                (rst),
  .reg_addr           (reg_addr),
  .reg_wr             (reg_wr),
  .reg_rd             (reg_rd),
  .reg_rdata          (reg_rdata),
  .fb_div_out         (fb_div_out),
  .freq_estimate_word (freq_estimate_word),
  .loop_filter_tick   (loop_filter_tick),
  .prop_coeff         (prop_coeff),
  .integ_coeff        (integ_coeff),
  .third_coeff        (third_coeff)
);
`default_nettype wire

// [verification/testbench.sv]
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        feedback_clock_input = 1'b0;
  logic [23:0] freq_estimate_word = 24'ha5c33c;
  logic [7:0]  reg_rdata;
  logic        fb_div_out;
  logic        loop_filter_tick;
  logic [43:0] prop_coeff;
  logic [43:0] integ_coeff;
  logic [43:0] third_coeff;
  logic [7:0]  d;
  int          fails = 0;
  int          checked = 0;
  int          cycles = 0;
  int          fb_n = 0;
  int          tick_n = 0;

  dpdc_regs uut
  (
    .core_clk             (core_clk),
    .rst                  (rst),
    .reg_addr             (reg_addr),
    .reg_wdata            (reg_wdata),
    .reg_wr               (reg_wr),
    .reg_rd               (reg_rd),
    .reg_rdata            (reg_rdata),
    .feedback_clock_input (feedback_clock_input),
    .fb_div_out           (fb_div_out),
    .freq_estimate_word   (freq_estimate_word),
    .loop_filter_tick     (loop_filter_tick),
    .prop_coeff           (prop_coeff),
    .integ_coeff          (integ_coeff),
    .third_coeff          (third_coeff)
  );

  always #50 core_clk = ~core_clk;

  // pulse counters; timeout cuts a hang short
  always @(posedge core_clk)
  begin
    cycles++;
    if (fb_div_out === 1'b1) fb_n++;
    if (loop_filter_tick === 1'b1) tick_n++;
    if (cycles == 5000)
    begin
      fails++;
      conclude();
    end
  end

  task automatic conclude;
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : conclude

  task automatic check(input logic [43:0] seen, input logic [43:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // data is taken in the single cycle it stands
  task automatic rd(input logic [15:0] a);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd

  function automatic logic [7:0] rw_mask(input logic [15:0] a);
    case (a)
      16'h0106:                     return 8'h81;
      16'h0107, 16'h010a:           return 8'h1f;
      16'h0109, 16'h010d, 16'h0110: return 8'h0f;
      16'h010b, 16'h010e, 16'h0111: return 8'h07;
      16'h0112, 16'h0113, 16'h0114: return 8'h00;
      default:                      return 8'hff;
    endcase
  endfunction : rw_mask

  // reset values, then every writable bit set through every address
  task automatic test_map;
    logic [7:0] wv;
    for (int a = 16'h0104; a <= 16'h0117; a++)
    begin
      if (a >= 16'h0112 && a <= 16'h0114)
        continue; // software stays off these
      rd(16'(a));
      if (a >= 16'h0115)
        check(44'(d), 44'(freq_estimate_word[8*(a-16'h0115) +: 8]));
      else
        check(44'(d), (a == 16'h0107) ? 44'h05 : 44'h00);
      wv = (a == 16'h0106) ? 8'h81 : 8'hff; // control register reserved bits left clear
      wr(16'(a), wv);
      rd(16'(a));
      if (a >= 16'h0115)
        check(44'(d), 44'(freq_estimate_word[8*(a-16'h0115) +: 8]));
      else
        check(44'(d), 44'(rw_mask(16'(a))));
    end
    wr(16'h0200, 8'hff);
    rd(16'h0200);
    check(44'(d), 44'h00);
  endtask : test_map

  task automatic test_coeff;
    wr(16'h0108, 8'h34); wr(16'h0109, 8'h12); wr(16'h010a, 8'h03); wr(16'h010b, 8'h02);
    wr(16'h010c, 8'hbc); wr(16'h010d, 8'h0a); wr(16'h010e, 8'h03);
    wr(16'h010f, 8'h00); wr(16'h0110, 8'h08); wr(16'h0111, 8'h07);
    #1 check(prop_coeff, 44'h468);
    check(integ_coeff, 44'h157);
    check(third_coeff, 44'h010);
    wr(16'h0108, 8'hff); wr(16'h0109, 8'h0f); wr(16'h010a, 8'h1f); wr(16'h010b, 8'h00);
    #1 check(prop_coeff, 44'h7ff80000000);
  endtask : test_coeff

  // window lengths are multiples of the period, so phase does not matter
  task automatic test_tick;
    wr(16'h0107, 8'h00);
    repeat (40) @(posedge core_clk);
    #1 tick_n = 0;
    repeat (8) @(posedge core_clk);
    #1 check(44'(tick_n), 44'd8);
    wr(16'h0107, 8'h02);
    repeat (40) @(posedge core_clk);
    #1 tick_n = 0;
    repeat (16) @(posedge core_clk);
    #1 check(44'(tick_n), 44'd4);
  endtask : test_tick

  task automatic toggles(input int n);
    repeat (n)
    begin
      repeat (2) @(posedge core_clk);
      feedback_clock_input <= ~feedback_clock_input;
    end
    repeat (4) @(posedge core_clk);
  endtask : toggles

  // fresh reset first: earlier traffic left the divider value and control bits programmed
  task automatic test_fb;
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    wr(16'h0104, 8'h02); // ratio 3, slow input: no prescale needed
    #1 fb_n = 0;
    toggles(12);
    #1 check(44'(fb_n), 44'd2);
    wr(16'h0106, 8'h01);
    #1 fb_n = 0;
    toggles(24);
    #1 check(44'(fb_n), 44'd2);
    wr(16'h0104, 8'h00);
    wr(16'h0106, 8'h80);
    repeat (4) @(posedge core_clk);
    #1 fb_n = 0;
    toggles(1);
    #1 check(44'(fb_n), 44'd0);
    toggles(1);
    #1 check(44'(fb_n), 44'd1);
  endtask : test_fb

  initial
  begin
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    test_map();
    test_coeff();
    test_tick();
    test_fb();
    conclude();
  end
endmodule : testbench
`default_nettype wire
